// ==== design/meter_map_cfg.svh ====
`ifndef METER_MAP_CFG_SVH
`define METER_MAP_CFG_SVH

// ==========================================================================
// register offsets
`define OFS_MEASURED_VALUE      8'h01
`define OFS_MEASURE_STATUS      8'h02
`define OFS_DECIMAL_POSITION    8'h03
`define OFS_OUTPUT_STATE        8'h04
`define OFS_CAPTURED_EXTREME    8'h06
`define OFS_SENSOR_SELECT       8'h10
`define OFS_FILTER_STRENGTH     8'h12
`define OFS_SCALE_OFFSET        8'h18
`define OFS_BUS_NODE_ADDRESS    8'h20
`define OFS_IDENTITY_WORD       8'h21
`define OFS_LINE_RATE_SELECT    8'h22
`define OFS_BUS_WRITE_PERMIT    8'h23
`define OFS_EDIT_PERMITS        8'h24
`define OFS_REPLY_DELAY_SELECT  8'h25
`define OFS_FRAME_GAP_TIMEOUT   8'h27
`define OFS_DISPLAY_BRIGHTNESS  8'h2D
`define OFS_EDIT_STYLE          8'h2F
`define OFS_R1_SETPOINT         8'h30
`define OFS_R1_HYSTERESIS       8'h31
`define OFS_R1_MODE             8'h32
`define OFS_R1_ON_DELAY         8'h33
`define OFS_R1_OFF_DELAY        8'h34
`define OFS_R1_TIME_BASE        8'h35
`define OFS_R1_FAULT_ACTION     8'h36
`define OFS_R1_SECOND_SETPOINT  8'h37
`define OFS_R2_SETPOINT         8'h38
`define OFS_R2_HYSTERESIS       8'h39
`define OFS_R2_MODE             8'h3A
`define OFS_R2_ON_DELAY         8'h3B

// ==========================================================================
// field positions and fixed values
`define POS_ALARM_LED           4
`define VAL_STATUS_VALID        16'h0000
`define VAL_STATUS_OVER         16'h00A0
`define VAL_STATUS_UNDER        16'h0060
`define VAL_DECIMAL_POSITION    16'h0001
// arbitrary value
`define VAL_IDENTITY_WORD       16'h5A5A

// ==========================================================================
// exception codes
`define EXC_NONE                8'h00
`define EXC_BAD_ADDRESS         8'h02
`define EXC_BAD_VALUE           8'h03
`define EXC_NO_PERMIT           8'h08

// ==========================================================================
// reset values
`define RST_NODE_ADDRESS        8'h01
`define RST_LINE_RATE           3'h3
`define RST_BRIGHTNESS          4'h8

`endif

// ==== design/meter_map_pkg.sv ====
`default_nettype none
package meter_map_pkg;

  // ========================================================================
  // complete state of the register bank
  typedef struct packed {
    logic [1:0]  sensor;
    logic [2:0]  smoothing_level;
    logic [15:0] scale_shift;
    logic [7:0]  node_addr;
    logic [2:0]  line_rate;
    logic        bus_write_gate;
    logic [2:0]  edit_permit;
    logic [2:0]  reply_delay;
    logic [6:0]  frame_gap_limit;
    logic [3:0]  brightness;
    logic        edit_style;
    logic [15:0] r1_first_threshold;
    logic [15:0] r1_threshold_hysteresis;
    logic [2:0]  r1_mode;
    logic [9:0]  r1_on_delay;
    logic [9:0]  r1_switch_off_delay;
    logic        r1_time_base;
    logic [1:0]  r1_fault_reaction;
    logic [15:0] r1_second_threshold;
    logic [15:0] r2_first_threshold;
    logic [15:0] r2_threshold_hysteresis;
    logic [2:0]  r2_mode;
    logic [9:0]  r2_on_delay;
    logic [2:0]  bus_relay;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0]  rsp_exc;
    logic [7:0]  rsp_node_addr;
    logic [2:0]  rsp_line_rate;
  } bank_s;

endpackage
`default_nettype wire

// ==== design/meter_modbus_register_map.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "meter_map_cfg.svh"

// Function
// RULE1 - measurement readable at 01h, read-only
// RULE2 - 02h reports valid, over or under
// RULE3 - 03h always reads one
// RULE4 - 04h reads relays bits 0-2, LED bit 4
// RULE5 - 04h write drives only relay bits
// RULE6 - peak value readable at 06h, read-only
// RULE7 - 10h sensor type, 0 to 2
// RULE8 - 12h filtering strength, 0 to 5
// RULE9 - 18h signed offset, -99 to 99
// RULE10 - address change replied with old address
// RULE11 - fixed identification word at 21h
// RULE12 - 22h baud code, 0 to 7
// RULE13 - baud change replied at new rate
// RULE14 - 23h gates configuration writes
// RULE15 - bus may clear, never set, permit
// RULE16 - refused write answers exception 08h
// RULE17 - 24h three relay edit permit bits
// RULE18 - 25h reply delay code, 0 to 5
// RULE19 - 27h frame gap limit, 0 to 99
// RULE20 - 2Dh brightness, 1 to 8
// RULE21 - 2Fh edit style, 0 or 1
// RULE22 - relay one setpoints and hysteresis words
// RULE23 - relay mode codes 0 to 5
// RULE24 - relay one delays and time base
// RULE25 - relay one fault reaction 0 to 2
// RULE26 - relay two words at 38h upward
// RULE27 - read-only unchanged, out-of-range not stored
module meter_modbus_register_map
  import meter_map_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic        i_req_write,
  input  wire logic [7:0]  i_req_addr,
  input  wire logic [15:0] i_req_wdata,
  input  wire logic [15:0] i_measured_value,
  input  wire logic        i_over_range,
  input  wire logic        i_under_range,
  input  wire logic [15:0] i_captured_extreme,
  input  wire logic [2:0]  i_relay_state,
  input  wire logic        i_alarm_led,
  input  wire logic        i_menu_write_enable,
  output var  logic        o_rsp_valid,
  output var  logic [15:0] o_rsp_data,
  output var  logic [7:0]  o_rsp_exc,
  output var  logic [7:0]  o_rsp_node_addr,
  output var  logic [2:0]  o_rsp_line_rate,
  output var  logic [1:0]  o_sensor_select,
  output var  logic [2:0]  o_smoothing_level,
  output var  logic [15:0] o_scale_shift,
  output var  logic [7:0]  o_node_addr,
  output var  logic [2:0]  o_line_rate,
  output var  logic        o_bus_write_gate,
  output var  logic [2:0]  o_edit_permit,
  output var  logic [2:0]  o_reply_delay,
  output var  logic [6:0]  o_frame_gap_limit,
  output var  logic [3:0]  o_brightness,
  output var  logic        o_edit_style,
  output var  logic [15:0] o_r1_first_threshold,
  output var  logic [15:0] o_r1_threshold_hysteresis,
  output var  logic [2:0]  o_r1_mode,
  output var  logic [9:0]  o_r1_on_delay,
  output var  logic [9:0]  o_r1_switch_off_delay,
  output var  logic        o_r1_time_base,
  output var  logic [1:0]  o_r1_fault_reaction,
  output var  logic [15:0] o_r1_second_threshold,
  output var  logic [15:0] o_r2_first_threshold,
  output var  logic [15:0] o_r2_threshold_hysteresis,
  output var  logic [2:0]  o_r2_mode,
  output var  logic [9:0]  o_r2_on_delay,
  output var  logic [2:0]  o_bus_relay
);

  // ========================================================================
  // helpers
  function automatic logic in_rng(input logic [15:0] v, input int lo, input int hi);
    return (int'($signed(v)) >= lo) && (int'($signed(v)) <= hi);
  endfunction

  bank_s st;
  bank_s next_st;

  // reset picture of the whole bank
  localparam bank_s reset_state = '{
    node_addr:      `RST_NODE_ADDRESS,
    line_rate:      `RST_LINE_RATE,
    bus_write_gate: 1'b1,
    brightness:     `RST_BRIGHTNESS,
    rsp_node_addr:  `RST_NODE_ADDRESS,
    rsp_line_rate:  `RST_LINE_RATE,
    default:        '0
  };

  // ========================================================================
  // read decode
  logic [15:0] rd_word;
  logic        rd_hit;
  logic        ro_hit;

  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    ro_hit  = 1'b0;
    unique case (i_req_addr)
      // RULE1 measurement word
      `OFS_MEASURED_VALUE: begin
        rd_word = i_measured_value;
        ro_hit  = 1'b1;
      end
      // RULE2 range status
      `OFS_MEASURE_STATUS: begin
        rd_word = i_over_range ? `VAL_STATUS_OVER :
                  (i_under_range ? `VAL_STATUS_UNDER : `VAL_STATUS_VALID);
        ro_hit  = 1'b1;
      end
      // RULE3 fixed decimal point
      `OFS_DECIMAL_POSITION: begin
        rd_word = `VAL_DECIMAL_POSITION;
        ro_hit  = 1'b1;
      end
      // RULE4 relay and LED picture
      `OFS_OUTPUT_STATE: begin
        rd_word                 = {13'h0000, i_relay_state};
        rd_word[`POS_ALARM_LED] = i_alarm_led;
      end
      // RULE6 peak word
      `OFS_CAPTURED_EXTREME: begin
        rd_word = i_captured_extreme;
        ro_hit  = 1'b1;
      end
      `OFS_SENSOR_SELECT:      rd_word = {14'h0000, st.sensor};
      `OFS_FILTER_STRENGTH:    rd_word = {13'h0000, st.smoothing_level};
      `OFS_SCALE_OFFSET:       rd_word = st.scale_shift;
      `OFS_BUS_NODE_ADDRESS:   rd_word = {8'h00, st.node_addr};
      // RULE11 identity word, value arbitrary
      `OFS_IDENTITY_WORD: begin
        rd_word = `VAL_IDENTITY_WORD;
        ro_hit  = 1'b1;
      end
      `OFS_LINE_RATE_SELECT:   rd_word = {13'h0000, st.line_rate};
      `OFS_BUS_WRITE_PERMIT:   rd_word = {15'h0000, st.bus_write_gate};
      `OFS_EDIT_PERMITS:       rd_word = {13'h0000, st.edit_permit};
      `OFS_REPLY_DELAY_SELECT: rd_word = {13'h0000, st.reply_delay};
      `OFS_FRAME_GAP_TIMEOUT:  rd_word = {9'h000, st.frame_gap_limit};
      `OFS_DISPLAY_BRIGHTNESS: rd_word = {12'h000, st.brightness};
      `OFS_EDIT_STYLE:         rd_word = {15'h0000, st.edit_style};
      `OFS_R1_SETPOINT:        rd_word = st.r1_first_threshold;
      `OFS_R1_HYSTERESIS:      rd_word = st.r1_threshold_hysteresis;
      `OFS_R1_MODE:            rd_word = {13'h0000, st.r1_mode};
      `OFS_R1_ON_DELAY:        rd_word = {6'h00, st.r1_on_delay};
      `OFS_R1_OFF_DELAY:       rd_word = {6'h00, st.r1_switch_off_delay};
      `OFS_R1_TIME_BASE:       rd_word = {15'h0000, st.r1_time_base};
      `OFS_R1_FAULT_ACTION:    rd_word = {14'h0000, st.r1_fault_reaction};
      `OFS_R1_SECOND_SETPOINT: rd_word = st.r1_second_threshold;
      `OFS_R2_SETPOINT:        rd_word = st.r2_first_threshold;
      `OFS_R2_HYSTERESIS:      rd_word = st.r2_threshold_hysteresis;
      `OFS_R2_MODE:            rd_word = {13'h0000, st.r2_mode};
      `OFS_R2_ON_DELAY:        rd_word = {6'h00, st.r2_on_delay};
      default:                 rd_hit  = 1'b0;
    endcase
  end

  // ========================================================================
  // write range check
  logic wr_legal;

  always_comb begin
    wr_legal = 1'b0;
    unique case (i_req_addr)
      `OFS_OUTPUT_STATE:       wr_legal = 1'b1;
      // RULE7 sensor range
      `OFS_SENSOR_SELECT:      wr_legal = in_rng(i_req_wdata, 0, 2);
      // RULE8 filter range
      `OFS_FILTER_STRENGTH:    wr_legal = in_rng(i_req_wdata, 0, 5);
      // RULE9 offset range
      `OFS_SCALE_OFFSET:       wr_legal = in_rng(i_req_wdata, -99, 99);
      `OFS_BUS_NODE_ADDRESS:   wr_legal = in_rng(i_req_wdata, 0, 199);
      // RULE12 baud code range
      `OFS_LINE_RATE_SELECT:   wr_legal = in_rng(i_req_wdata, 0, 7);
      // RULE15 only clearing allowed
      `OFS_BUS_WRITE_PERMIT:   wr_legal = (i_req_wdata == 16'h0000);
      // RULE17 three permit bits
      `OFS_EDIT_PERMITS:       wr_legal = in_rng(i_req_wdata, 0, 7);
      // RULE18 delay code range
      `OFS_REPLY_DELAY_SELECT: wr_legal = in_rng(i_req_wdata, 0, 5);
      // RULE19 gap limit range
      `OFS_FRAME_GAP_TIMEOUT:  wr_legal = in_rng(i_req_wdata, 0, 99);
      // RULE20 brightness range
      `OFS_DISPLAY_BRIGHTNESS: wr_legal = in_rng(i_req_wdata, 1, 8);
      // RULE21 edit style range
      `OFS_EDIT_STYLE:         wr_legal = in_rng(i_req_wdata, 0, 1);
      // RULE22 threshold ranges
      `OFS_R1_SETPOINT,
      `OFS_R1_SECOND_SETPOINT,
      `OFS_R2_SETPOINT:        wr_legal = in_rng(i_req_wdata, -999, 9999);
      `OFS_R1_HYSTERESIS,
      `OFS_R2_HYSTERESIS:      wr_legal = in_rng(i_req_wdata, -999, 999);
      // RULE23 mode range
      `OFS_R1_MODE,
      `OFS_R2_MODE:            wr_legal = in_rng(i_req_wdata, 0, 5);
      // RULE24 delay and time base ranges
      `OFS_R1_ON_DELAY,
      `OFS_R1_OFF_DELAY,
      `OFS_R2_ON_DELAY:        wr_legal = in_rng(i_req_wdata, 0, 999);
      `OFS_R1_TIME_BASE:       wr_legal = in_rng(i_req_wdata, 0, 1);
      // RULE25 fault reaction range
      `OFS_R1_FAULT_ACTION:    wr_legal = in_rng(i_req_wdata, 0, 2);
      default:                 wr_legal = 1'b0;
    endcase
  end

  // ========================================================================
  // next state
  logic wr_req;
  logic wr_do;
  logic [7:0] wr_exc;

  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    wr_req            = i_req && i_req_write;
    wr_exc            = `EXC_NONE;
    if (!rd_hit || (wr_req && ro_hit)) begin
      // RULE27 read-only and unmapped refused
      wr_exc = `EXC_BAD_ADDRESS;
    end else if (wr_req && !st.bus_write_gate && i_req_addr != `OFS_OUTPUT_STATE) begin
      // RULE16 no permission answer
      wr_exc = `EXC_NO_PERMIT;
    end else if (wr_req && !wr_legal) begin
      // RULE27 out-of-range not stored
      wr_exc = `EXC_BAD_VALUE;
    end
    wr_do = wr_req && (wr_exc == `EXC_NONE);
    if (wr_do) begin
      unique case (i_req_addr)
        // RULE5 relay bits only
        `OFS_OUTPUT_STATE:       next_st.bus_relay = i_req_wdata[2:0];
        `OFS_SENSOR_SELECT:      next_st.sensor = i_req_wdata[1:0];
        `OFS_FILTER_STRENGTH:    next_st.smoothing_level = i_req_wdata[2:0];
        `OFS_SCALE_OFFSET:       next_st.scale_shift = i_req_wdata;
        `OFS_BUS_NODE_ADDRESS:   next_st.node_addr = i_req_wdata[7:0];
        `OFS_LINE_RATE_SELECT:   next_st.line_rate = i_req_wdata[2:0];
        // RULE14 bus clears the gate
        `OFS_BUS_WRITE_PERMIT:   next_st.bus_write_gate = 1'b0;
        `OFS_EDIT_PERMITS:       next_st.edit_permit = i_req_wdata[2:0];
        `OFS_REPLY_DELAY_SELECT: next_st.reply_delay = i_req_wdata[2:0];
        `OFS_FRAME_GAP_TIMEOUT:  next_st.frame_gap_limit = i_req_wdata[6:0];
        `OFS_DISPLAY_BRIGHTNESS: next_st.brightness = i_req_wdata[3:0];
        `OFS_EDIT_STYLE:         next_st.edit_style = i_req_wdata[0];
        `OFS_R1_SETPOINT:        next_st.r1_first_threshold = i_req_wdata;
        `OFS_R1_HYSTERESIS:      next_st.r1_threshold_hysteresis = i_req_wdata;
        `OFS_R1_MODE:            next_st.r1_mode = i_req_wdata[2:0];
        `OFS_R1_ON_DELAY:        next_st.r1_on_delay = i_req_wdata[9:0];
        `OFS_R1_OFF_DELAY:       next_st.r1_switch_off_delay = i_req_wdata[9:0];
        `OFS_R1_TIME_BASE:       next_st.r1_time_base = i_req_wdata[0];
        `OFS_R1_FAULT_ACTION:    next_st.r1_fault_reaction = i_req_wdata[1:0];
        `OFS_R1_SECOND_SETPOINT: next_st.r1_second_threshold = i_req_wdata;
        // RULE26 relay two words
        `OFS_R2_SETPOINT:        next_st.r2_first_threshold = i_req_wdata;
        `OFS_R2_HYSTERESIS:      next_st.r2_threshold_hysteresis = i_req_wdata;
        `OFS_R2_MODE:            next_st.r2_mode = i_req_wdata[2:0];
        `OFS_R2_ON_DELAY:        next_st.r2_on_delay = i_req_wdata[9:0];
        default:                 next_st.bus_relay = st.bus_relay;
      endcase
    end
    // RULE15 only the menu sets the gate
    if (i_menu_write_enable) begin
      next_st.bus_write_gate = 1'b1;
    end
    if (i_req) begin
      next_st.rsp_valid     = 1'b1;
      next_st.rsp_exc       = wr_exc;
      next_st.rsp_data      = i_req_write ? i_req_wdata : rd_word;
      // RULE10 reply with old address
      next_st.rsp_node_addr = st.node_addr;
      // RULE13 reply at new rate
      next_st.rsp_line_rate = next_st.line_rate;
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= reset_state;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs
  assign o_rsp_valid               = st.rsp_valid;
  assign o_rsp_data                = st.rsp_data;
  assign o_rsp_exc                 = st.rsp_exc;
  assign o_rsp_node_addr           = st.rsp_node_addr;
  assign o_rsp_line_rate           = st.rsp_line_rate;
  assign o_sensor_select           = st.sensor;
  assign o_smoothing_level         = st.smoothing_level;
  assign o_scale_shift             = st.scale_shift;
  assign o_node_addr               = st.node_addr;
  assign o_line_rate               = st.line_rate;
  assign o_bus_write_gate          = st.bus_write_gate;
  assign o_edit_permit             = st.edit_permit;
  assign o_reply_delay             = st.reply_delay;
  assign o_frame_gap_limit         = st.frame_gap_limit;
  assign o_brightness              = st.brightness;
  assign o_edit_style              = st.edit_style;
  assign o_r1_first_threshold      = st.r1_first_threshold;
  assign o_r1_threshold_hysteresis = st.r1_threshold_hysteresis;
  assign o_r1_mode                 = st.r1_mode;
  assign o_r1_on_delay             = st.r1_on_delay;
  assign o_r1_switch_off_delay     = st.r1_switch_off_delay;
  assign o_r1_time_base            = st.r1_time_base;
  assign o_r1_fault_reaction       = st.r1_fault_reaction;
  assign o_r1_second_threshold     = st.r1_second_threshold;
  assign o_r2_first_threshold      = st.r2_first_threshold;
  assign o_r2_threshold_hysteresis = st.r2_threshold_hysteresis;
  assign o_r2_mode                 = st.r2_mode;
  assign o_r2_on_delay             = st.r2_on_delay;
  assign o_bus_relay               = st.bus_relay;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  chk_status_over_code: assert property ( // RULE2
    i_req && !i_req_write && i_req_addr == `OFS_MEASURE_STATUS && i_over_range
    |=> o_rsp_valid && o_rsp_data == 16'h00A0)
    else $error("status over-range code wrong");

  chk_decimal_const: assert property ( // RULE3
    i_req && !i_req_write && i_req_addr == `OFS_DECIMAL_POSITION
    |=> o_rsp_data == 16'h0001 && o_rsp_exc == 8'h00)
    else $error("decimal position not one");

  chk_led_bit_read: assert property ( // RULE4
    i_req && !i_req_write && i_req_addr == `OFS_OUTPUT_STATE
    |=> o_rsp_data[4] == $past(i_alarm_led) && o_rsp_data[15:5] == 11'h000)
    else $error("output state picture wrong");

  chk_relay_write: assert property ( // RULE5
    i_req && i_req_write && i_req_addr == `OFS_OUTPUT_STATE
    |=> o_bus_relay == $past(i_req_wdata[2:0]) && o_rsp_exc == 8'h00)
    else $error("relay write not applied");

  chk_old_address: assert property ( // RULE10
    i_req && i_req_write && i_req_addr == `OFS_BUS_NODE_ADDRESS
    |=> o_rsp_node_addr == $past(o_node_addr))
    else $error("reply not on old address");

  chk_new_rate: assert property ( // RULE13
    i_req && i_req_write && i_req_addr == `OFS_LINE_RATE_SELECT
    |=> o_rsp_line_rate == o_line_rate)
    else $error("reply not at new rate");

  chk_gate_never_set: assert property ( // RULE15
    !o_bus_write_gate && !i_menu_write_enable |=> !o_bus_write_gate)
    else $error("bus set the write gate");

  chk_no_permit_exc: assert property ( // RULE16
    i_req && i_req_write && !o_bus_write_gate && i_req_addr == `OFS_SENSOR_SELECT
    |=> o_rsp_valid && o_rsp_exc == `EXC_NO_PERMIT)
    else $error("missing no-permit exception");

  chk_range_kept: assert property ( // RULE27
    o_brightness >= 4'h1 && o_brightness <= 4'h8 && o_r1_mode <= 3'h5)
    else $error("stored value out of range");

endmodule // meter_modbus_register_map

`default_nettype wire

// ==== dv/bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// remote master, one word per access
module bus_master_model (
  input  wire logic        i_clk_sys,
  output var  logic        o_req,
  output var  logic        o_req_write,
  output var  logic [7:0]  o_req_addr,
  output var  logic [15:0] o_req_wdata
);
  initial begin
    o_req = 1'b0;
    o_req_write = 1'b0;
    o_req_addr = 8'h00;
    o_req_wdata = 16'h0000;
  end
  // request held from falling edge over one rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_req <= 1'b1;
    o_req_write <= wr;
    o_req_addr <= a;
    o_req_wdata <= d;
    @(posedge i_clk_sys);
  endtask
  // request drops; address and data lines show the inverse of the last value, write flag kept
  task automatic idle();
    @(negedge i_clk_sys);
    o_req <= 1'b0;
    o_req_addr <= ~o_req_addr;
    o_req_wdata <= ~o_req_wdata;
  endtask
endmodule // bus_master_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "meter_map_cfg.svh"
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  typedef struct packed {logic [15:0] d; logic [7:0] e; logic [7:0] n; logic [2:0] r;} exp_s;
  logic clk, rst_n, req, wr, over, under, led, menu, rsp_valid, gate;
  logic [7:0] addr, rsp_exc, rsp_node, node_addr, node;
  logic [15:0] wdata, meas, ext, rsp_data, v;
  logic [2:0] rs, rsp_rate, line_rate, bus_relay, rate;
  logic [3:0] bright;
  logic [1:0] sel, r1f;
  logic [2:0] smooth, permit, dly, r1m, r2m;
  logic [6:0] gap;
  logic edit, r1tb;
  logic [9:0] r1on, r1off, r2on;
  logic [15:0] shift, r1t, r1h, r1t2, r2t, r2h;
  logic [15:0] cfg[22];
  exp_s exp_q[$];
  exp_s x;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] ro[6] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h21, 8'h05};
  logic [7:0] ta[22] = '{8'h10, 8'h12, 8'h18, 8'h20, 8'h22, 8'h24, 8'h25, 8'h27, 8'h2D,
    8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B};
  logic signed [15:0] tl[22] = '{0, 0, -99, 0, 0, 0, 0, 0, 1, 0, -999, -999, 0, 0, 0, 0, 0,
    -999, -999, -999, 0, 0};
  logic signed [15:0] th[22] = '{2, 5, 99, 199, 7, 7, 5, 99, 8, 1, 9999, 999, 5, 999, 999, 1,
    2, 9999, 9999, 999, 5, 999};

  bus_master_model i_bus_master_model (.i_clk_sys(clk), .o_req(req), .o_req_write(wr),
    .o_req_addr(addr), .o_req_wdata(wdata));
  meter_modbus_register_map i_meter_modbus_register_map (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_req(req), .i_req_write(wr), .i_req_addr(addr),
    .i_req_wdata(wdata), .i_measured_value(meas), .i_over_range(over),
    .i_under_range(under), .i_captured_extreme(ext), .i_relay_state(rs),
    .i_alarm_led(led), .i_menu_write_enable(menu), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .o_rsp_exc(rsp_exc), .o_rsp_node_addr(rsp_node),
    .o_rsp_line_rate(rsp_rate), .o_sensor_select(sel), .o_smoothing_level(smooth),
    .o_scale_shift(shift), .o_node_addr(node_addr), .o_line_rate(line_rate),
    .o_bus_write_gate(gate), .o_edit_permit(permit), .o_reply_delay(dly),
    .o_frame_gap_limit(gap), .o_brightness(bright), .o_edit_style(edit),
    .o_r1_first_threshold(r1t), .o_r1_threshold_hysteresis(r1h), .o_r1_mode(r1m),
    .o_r1_on_delay(r1on), .o_r1_switch_off_delay(r1off), .o_r1_time_base(r1tb),
    .o_r1_fault_reaction(r1f), .o_r1_second_threshold(r1t2), .o_r2_first_threshold(r2t),
    .o_r2_threshold_hysteresis(r2h), .o_r2_mode(r2m), .o_r2_on_delay(r2on),
    .o_bus_relay(bus_relay));

  // configuration outputs in the order of ta
  assign cfg = '{16'(sel), 16'(smooth), shift, 16'(node_addr), 16'(line_rate), 16'(permit),
    16'(dly), 16'(gap), 16'(bright), 16'(edit), r1t, r1h, 16'(r1m), 16'(r1on), 16'(r1off),
    16'(r1tb), 16'(r1f), r1t2, r2t, r2h, 16'(r2m), 16'(r2on)};

  always #10 clk = ~clk;

  // ==========================================
  // closing report
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // note the expected answer, then issue the access
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [7:0] e);
    if (w && e == `EXC_NONE && a == `OFS_LINE_RATE_SELECT) rate = d[2:0];
    exp_q.push_back('{d, e, node, rate});
    if (w && e == `EXC_NONE && a == `OFS_BUS_NODE_ADDRESS) node = d[7:0];
    i_bus_master_model.access(w, a, d);
  endtask

  // ==========================================
  // answer watcher
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED rsp_valid expected 0 seen 1");
      end else begin
        x = exp_q.pop_front();
        `CHK("rsp_exc", x.e, rsp_exc)
        if (x.e == `EXC_NONE) `CHK("rsp_data", x.d, rsp_data)
        `CHK("rsp_node", x.n, rsp_node)
        `CHK("rsp_rate", x.r, rsp_rate)
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {meas, ext, rs, over, under, led, menu} = '0;
    void'($urandom(32'hE270CDE7));
    repeat (4) @(negedge clk);
    `CHK("node_addr", `RST_NODE_ADDRESS, node_addr)
    `CHK("line_rate", `RST_LINE_RATE, line_rate)
    `CHK("gate", 1'b1, gate)
    `CHK("bright", `RST_BRIGHTNESS, bright)
    node = `RST_NODE_ADDRESS;
    rate = `RST_LINE_RATE;
    rst_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_bus_master_model.idle();
      meas = 16'($urandom_range(6999)) - 16'h03E7;
      ext = 16'($urandom_range(6999)) - 16'h03E7;
      {under, over} = k[1:0];
      rs = 3'($urandom);
      led = k[0];
      acc(1'b0, `OFS_MEASURED_VALUE, meas, `EXC_NONE);
      acc(1'b0, `OFS_MEASURE_STATUS, k[0] ? `VAL_STATUS_OVER : k[1] ? `VAL_STATUS_UNDER
        : `VAL_STATUS_VALID, `EXC_NONE);
      acc(1'b0, `OFS_DECIMAL_POSITION, `VAL_DECIMAL_POSITION, `EXC_NONE);
      acc(1'b0, `OFS_OUTPUT_STATE, {11'h000, led, 1'b0, rs}, `EXC_NONE);
      acc(1'b0, `OFS_CAPTURED_EXTREME, ext, `EXC_NONE);
      acc(1'b0, `OFS_IDENTITY_WORD, `VAL_IDENTITY_WORD, `EXC_NONE);
    end
    foreach (ro[i]) acc(1'b1, ro[i], 16'h1234, `EXC_BAD_ADDRESS);
    acc(1'b0, 8'h05, 16'h0000, `EXC_BAD_ADDRESS);
    acc(1'b0, `OFS_DECIMAL_POSITION, `VAL_DECIMAL_POSITION, `EXC_NONE);
    $display("test read_only done");
    for (int i = 0; i < 22; i++) begin
      acc(1'b1, ta[i], th[i], `EXC_NONE);
      acc(1'b1, ta[i], th[i] + 16'h0001, `EXC_BAD_VALUE);
      acc(1'b1, ta[i], tl[i] - 16'h0001, `EXC_BAD_VALUE);
      v = tl[i] + 16'($urandom_range(32'(th[i] - tl[i])));
      acc(1'b1, ta[i], v, `EXC_NONE);
      acc(1'b0, ta[i], v, `EXC_NONE);
      `CHK("cfg_out", v, cfg[i])
    end
    i_bus_master_model.idle();
    @(negedge clk);
    `CHK("node_addr", node, node_addr)
    `CHK("line_rate", rate, line_rate)
    $display("test ranges done");
    acc(1'b1, `OFS_BUS_WRITE_PERMIT, 16'h0001, `EXC_BAD_VALUE);
    acc(1'b1, `OFS_OUTPUT_STATE, 16'hFFFF, `EXC_NONE);
    acc(1'b1, `OFS_BUS_WRITE_PERMIT, 16'h0000, `EXC_NONE);
    acc(1'b1, `OFS_SENSOR_SELECT, 16'h0001, `EXC_NO_PERMIT);
    acc(1'b1, `OFS_IDENTITY_WORD, 16'h0001, `EXC_BAD_ADDRESS);
    i_bus_master_model.idle();
    @(negedge clk);
    `CHK("bus_relay", 3'h7, bus_relay)
    `CHK("gate", 1'b0, gate)
    acc(1'b1, `OFS_OUTPUT_STATE, 16'h0010, `EXC_NONE);
    i_bus_master_model.idle();
    @(negedge clk);
    `CHK("bus_relay", 3'h0, bus_relay)
    menu = 1'b1;
    @(negedge clk);
    menu = 1'b0;
    acc(1'b1, `OFS_SENSOR_SELECT, 16'h0002, `EXC_NONE);
    acc(1'b0, `OFS_SENSOR_SELECT, 16'h0002, `EXC_NONE);
    i_bus_master_model.idle();
    repeat (3) @(negedge clk);
    `CHK("pending", 0, exp_q.size())
    $display("test write_gate done");
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("node_addr", `RST_NODE_ADDRESS, node_addr)
    `CHK("bright", `RST_BRIGHTNESS, bright)
    node = `RST_NODE_ADDRESS;
    rate = `RST_LINE_RATE;
    rst_n = 1'b1;
    acc(1'b0, `OFS_BUS_NODE_ADDRESS, 16'(`RST_NODE_ADDRESS), `EXC_NONE);
    i_bus_master_model.idle();
    repeat (2) @(negedge clk);
    `CHK("pending", 0, exp_q.size())
    $display("test reset done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
